// >>> verilog/i2cm_defines.svh
/*
 * timing constants of the two-wire bus master.
 * assumes a 100 MHz ref_clk; one bit is 6 low and 4 high phase ticks.
 */
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

// ref_clk period in ns and tick period in ns
`define I2CM_REF_PERIOD_NS  10
`define I2CM_TICK_NS        260
// timer period value; 12 keeps the bit rate just under the fast limit
`define I2CM_TIMER_PERIOD_VALUE 5'h0C
// last value of the tick divider: 2 * (1 + timer period value) - 1
`define I2CM_TICK_LAST      5'h19
// last tick index of each phase
`define I2CM_LOW_LAST       3'h5
`define I2CM_HIGH_LAST      3'h3
// tick on which the data line is sampled in the high phase
`define I2CM_SAMPLE_TICK    3'h1
// last bit index of a byte slot (eight data bits and the acknowledge)
`define I2CM_ACK_BIT        4'h8

`endif

// >>> verilog/i2cm_pkg.sv
/*
 * types of the two-wire bus master.
 * assumes i2cm_defines.svh holds the numbers.
 */
package i2cm_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RSTART,
        ST_START_A,
        ST_START_B,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_HOLD,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C,
        ST_LOST
    } i2cm_state_type;

    typedef logic [7:0] i2cm_byte_type;

endpackage

// >>> verilog/i2cm_stream_if.sv
/*
 * valid/ready byte stream between the modules of the bus master.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface i2cm_stream_if;
    logic                   valid;
    logic                   ready;
    i2cm_pkg::i2cm_byte_type data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/i2cm_skid2.sv
/*
 * two-entry buffer: an output register and one skid entry.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module i2cm_skid2 (
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst,
    // filling and draining sides
    i2cm_stream_if.snk     fill,
    i2cm_stream_if.src     drain
);
    import i2cm_pkg::*;

    logic          out_valid_q, out_valid_d;
    i2cm_byte_type out_data_q,  out_data_d;
    logic          skid_valid_q, skid_valid_d;
    i2cm_byte_type skid_data_q,  skid_data_d;
    logic          push;
    logic          pop;

    assign fill.ready  = ~skid_valid_q;
    assign drain.valid = out_valid_q;
    assign drain.data  = out_data_q;

    always_comb begin
        push         = fill.valid & ~skid_valid_q;
        pop          = out_valid_q & drain.ready;
        out_valid_d  = out_valid_q;
        out_data_d   = out_data_q;
        skid_valid_d = skid_valid_q;
        skid_data_d  = skid_data_q;
        if (!out_valid_q || pop) begin
            if (skid_valid_q) begin
                out_valid_d  = 1'b1;
                out_data_d   = skid_data_q;
                skid_valid_d = push;
                skid_data_d  = fill.data;
            end else begin
                out_valid_d = push;
                out_data_d  = fill.data;
            end
        end else if (push) begin
            skid_valid_d = 1'b1;
            skid_data_d  = fill.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_valid_q  <= 1'b0;
            out_data_q   <= 8'h00;
            skid_valid_q <= 1'b0;
            skid_data_q  <= 8'h00;
        end else begin
            out_valid_q  <= out_valid_d;
            out_data_q   <= out_data_d;
            skid_valid_q <= skid_valid_d;
            skid_data_q  <= skid_data_d;
        end
    end

endmodule

// >>> verilog/i2cm_master.sv
/*
 * bus master that drives the device's open-drain serial clock and data pins.
 * assumes external pull-ups on both lines; pins are asynchronous and synchronised.
 */
`timescale 1ns/1ps
`include "i2cm_defines.svh"

// Overview of operation
// - bus idle when both lines high
// - byte slot is eight bits plus acknowledge
// - unlimited bytes, each acknowledged, msb first
// - receiver may hold clock low to stall
// - start: data falls, stop: data rises, clock high
// - busy after start, free after stop
// - address seven bits then direction bit
// - data changes only while clock low
// - ack pulse: transmitter releases, receiver pulls low
// - unacknowledged address: master sends stop
// - master receiver leaves last byte unacknowledged
// - lost arbitration: release lines, wait for idle
module i2cm_master (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // byte command
    input  wire logic                    cmd_valid,
    output logic                         cmd_ready,
    input  wire logic                    cmd_start,
    input  wire logic                    cmd_stop,
    input  wire logic                    cmd_read,
    input  wire logic                    cmd_nack,
    input  wire i2cm_pkg::i2cm_byte_type cmd_data,
    // received bytes
    output logic                         rx_valid,
    input  wire logic                    rx_ready,
    output i2cm_pkg::i2cm_byte_type      rx_data,
    // status
    output logic                         done,
    output logic                         ack_error,
    output logic                         arb_lost,
    output logic                         bus_busy,
    // open-drain pins
    input  wire logic                    scl_in,
    output logic                         scl_out,
    output logic                         scl_oe,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe
);
    import i2cm_pkg::*;

    i2cm_stream_if push_if ();
    i2cm_stream_if pop_if ();

    i2cm_skid2 u_rx_buf (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fill    (push_if.snk),
        .drain   (pop_if.src)
    );

    assign pop_if.ready = rx_ready;
    assign rx_valid     = pop_if.valid;
    assign rx_data      = pop_if.data;

    // pin synchronisers and bus monitor
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
    logic busy_q, busy_d;
    logic start_det, stop_det, bus_idle;

    always_comb begin
        start_det = scl_s_q & sda_p_q & ~sda_s_q;
        stop_det  = scl_s_q & ~sda_p_q & sda_s_q;
        busy_d    = busy_q;
        if (start_det) begin
            busy_d = 1'b1;
        end else if (stop_det) begin
            busy_d = 1'b0;
        end
        bus_idle  = ~busy_q & scl_s_q & sda_s_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            busy_q  <= 1'b0;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            busy_q  <= busy_d;
        end
    end

    // tick divider
    logic [4:0] div_q, div_d;
    logic       tick_q, tick_d;

    always_comb begin
        tick_d = (div_q == `I2CM_TICK_LAST);
        div_d  = tick_d ? 5'h00 : div_q + 5'h01;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_q  <= 5'h00;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    // byte engine
    i2cm_state_type state_q, state_d;
    logic [2:0]     ph_q, ph_d;
    logic [3:0]     bit_q, bit_d;
    i2cm_byte_type  shift_q, shift_d;
    logic           stop_q, stop_d, read_q, read_d, nack_q, nack_d;
    logic           ackb_q, ackb_d, push_q, push_d;
    logic           restart_q, restart_d;
    logic           scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic           rdy_q, rdy_d, done_q, done_d;
    logic           aerr_q, aerr_d, lost_q, lost_d;
    logic           arb_hit, low_end, high_end, take;

    assign push_if.valid = push_q;
    assign push_if.data  = shift_q;

    always_comb begin
        state_d  = state_q;
        ph_d     = ph_q;
        bit_d    = bit_q;
        shift_d  = shift_q;
        stop_d   = stop_q;
        read_d   = read_q;
        nack_d   = nack_q;
        ackb_d   = ackb_q;
        restart_d = restart_q;
        push_d   = push_q & ~push_if.ready;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        done_d   = 1'b0;
        aerr_d   = aerr_q;
        lost_d   = lost_q;
        take     = cmd_valid & rdy_q;
        low_end  = tick_q & (ph_q == `I2CM_LOW_LAST);
        // high phase counts only once the clock line reads high
        high_end = tick_q & scl_s_q & (ph_q == `I2CM_HIGH_LAST);
        arb_hit  = (state_q == ST_BIT_HIGH) & scl_s_q & ~sda_oe_q & ~sda_s_q
                 & ~read_q & (bit_q != `I2CM_ACK_BIT);
        if (take) begin
            stop_d  = cmd_stop;
            read_d  = cmd_read;
            nack_d  = cmd_nack;
            shift_d = cmd_data;
            ph_d    = 3'h0;
            bit_d   = 4'h0;
            aerr_d  = 1'b0;
            lost_d  = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_START_A;
                end
            end
            ST_HOLD: begin
                if (take) begin
                    state_d = cmd_start ? ST_RSTART : ST_BIT_LOW;
                end
            end
            ST_RSTART: begin
                if (tick_q) begin
                    sda_oe_d = 1'b0;
                    ph_d     = ph_q + 3'h1;
                    if (low_end) begin
                        scl_oe_d  = 1'b0;
                        ph_d      = 3'h0;
                        restart_d = 1'b1;
                        state_d   = ST_START_A;
                    end
                end
            end
            ST_START_A: begin
                // a repeated start owns the bus, so busy must not block it
                if (!(scl_s_q && sda_s_q && (restart_q || !busy_q || ph_q != 3'h0))) begin
                    ph_d = 3'h0;
                end else if (tick_q) begin
                    ph_d = ph_q + 3'h1;
                    if (high_end) begin
                        sda_oe_d = 1'b1;
                        ph_d     = 3'h0;
                        restart_d = 1'b0;
                        state_d  = ST_START_B;
                    end
                end
            end
            ST_START_B: begin
                if (tick_q) begin
                    ph_d = ph_q + 3'h1;
                    if (ph_q == `I2CM_HIGH_LAST) begin
                        scl_oe_d = 1'b1;
                        ph_d     = 3'h0;
                        state_d  = ST_BIT_LOW;
                    end
                end
            end
            ST_BIT_LOW: begin
                if (tick_q && ph_q == 3'h0) begin
                    if (bit_q == `I2CM_ACK_BIT) begin
                        sda_oe_d = read_q & ~nack_q;
                    end else begin
                        sda_oe_d = ~read_q & ~shift_q[7];
                    end
                end
                if (tick_q && !(low_end && push_q)) begin
                    ph_d = ph_q + 3'h1;
                end
                if (low_end && !push_q) begin
                    scl_oe_d = 1'b0;
                    ph_d     = 3'h0;
                    state_d  = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH: begin
                if (!scl_s_q) begin
                    ph_d = 3'h0;
                end else if (tick_q) begin
                    ph_d = ph_q + 3'h1;
                end
                if (tick_q && scl_s_q && ph_q == `I2CM_SAMPLE_TICK) begin
                    if (bit_q == `I2CM_ACK_BIT) begin
                        ackb_d = sda_s_q;
                    end else if (read_q) begin
                        shift_d = {shift_q[6:0], sda_s_q};
                    end
                end
                if (arb_hit) begin
                    scl_oe_d = 1'b0;
                    sda_oe_d = 1'b0;
                    lost_d   = 1'b1;
                    done_d   = 1'b1;
                    state_d  = ST_LOST;
                end else if (high_end) begin
                    scl_oe_d = 1'b1;
                    ph_d     = 3'h0;
                    if (bit_q != `I2CM_ACK_BIT) begin
                        bit_d   = bit_q + 4'h1;
                        state_d = ST_BIT_LOW;
                        if (!read_q) begin
                            shift_d = {shift_q[6:0], 1'b0};
                        end else if (bit_q == 4'h7) begin
                            push_d = 1'b1;
                        end
                    end else if (!read_q && ackb_q) begin
                        aerr_d  = 1'b1;
                        state_d = ST_STOP_A;
                    end else if (stop_q) begin
                        state_d = ST_STOP_A;
                    end else begin
                        done_d  = 1'b1;
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_STOP_A: begin
                if (tick_q) begin
                    sda_oe_d = 1'b1;
                    ph_d     = ph_q + 3'h1;
                    if (low_end) begin
                        scl_oe_d = 1'b0;
                        ph_d     = 3'h0;
                        state_d  = ST_STOP_B;
                    end
                end
            end
            ST_STOP_B: begin
                if (!scl_s_q) begin
                    ph_d = 3'h0;
                end else if (tick_q) begin
                    ph_d = ph_q + 3'h1;
                    if (high_end) begin
                        sda_oe_d = 1'b0;
                        ph_d     = 3'h0;
                        state_d  = ST_STOP_C;
                    end
                end
            end
            ST_STOP_C: begin
                if (tick_q) begin
                    ph_d = ph_q + 3'h1;
                    if (ph_q == `I2CM_HIGH_LAST) begin
                        ph_d    = 3'h0;
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_LOST: begin
                if (bus_idle) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        rdy_d = (state_d == ST_IDLE) | (state_d == ST_HOLD);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            ph_q     <= 3'h0;
            bit_q    <= 4'h0;
            shift_q  <= 8'h00;
            stop_q   <= 1'b0;
            read_q   <= 1'b0;
            nack_q   <= 1'b0;
            ackb_q   <= 1'b1;
            push_q   <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rdy_q    <= 1'b0;
            done_q   <= 1'b0;
            aerr_q   <= 1'b0;
            lost_q   <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            ph_q     <= ph_d;
            bit_q    <= bit_d;
            shift_q  <= shift_d;
            stop_q   <= stop_d;
            read_q   <= read_d;
            nack_q   <= nack_d;
            ackb_q   <= ackb_d;
            push_q   <= push_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            rdy_q    <= rdy_d;
            done_q   <= done_d;
            aerr_q   <= aerr_d;
            lost_q   <= lost_d;
            restart_q <= restart_d;
        end
    end

    assign cmd_ready = rdy_q;
    assign done      = done_q;
    assign ack_error = aerr_q;
    assign arb_lost  = lost_q;
    assign bus_busy  = busy_q;
    assign scl_oe    = scl_oe_q;
    assign sda_oe    = sda_oe_q;
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;

    AST_FRESH_START_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_START_B && $past(state_q) == ST_START_A && !$past(scl_oe_q, 6))
        |-> $past(scl_s_q) && $past(sda_s_q))
        else $error("start issued while lines not high");
    AST_START_CLOCK_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sda_oe_q) && state_q == ST_START_B |-> !scl_oe_q && $past(scl_s_q))
        else $error("start data fall without clock high");
    AST_BUSY_ON_START: assert property (@(posedge ref_clk) disable iff (rst)
        start_det ##1 !stop_det [*2] |-> busy_q)
        else $error("bus not busy after start");
    AST_STABLE_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_HIGH && $past(state_q) == ST_BIT_HIGH |-> $stable(sda_oe_q))
        else $error("data changed while clock high");
    AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_HIGH && !read_q && bit_q != 4'h8 |-> sda_oe_q == !shift_q[7])
        else $error("transmitted bit differs from msb");
    AST_ACK_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_HIGH && bit_q == 4'h8 && !read_q |-> !sda_oe_q)
        else $error("transmitter held data in acknowledge slot");
    AST_LAST_NACK: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_HIGH && bit_q == 4'h8 && read_q |-> sda_oe_q == !nack_q)
        else $error("receiver acknowledge level wrong");
    AST_NINE_BITS: assert property (@(posedge ref_clk) disable iff (rst)
        $past(state_q) == ST_BIT_HIGH && bit_q != $past(bit_q)
        |-> bit_q == $past(bit_q) + 4'h1 && $past(bit_q) != 4'h8)
        else $error("byte slot exceeded nine bits");
    AST_STALL_HOLDS_CLOCK: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_LOW && push_q && !push_if.ready |=> scl_oe_q && state_q == ST_BIT_LOW)
        else $error("clock released while receive buffer full");
    AST_NACK_STOPS: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_BIT_HIGH && high_end && bit_q == 4'h8 && !read_q && ackb_q
        |=> state_q == ST_STOP_A ##[1:40] sda_oe_q)
        else $error("no stop after missing acknowledge");
    AST_ARB_RETIRE: assert property (@(posedge ref_clk) disable iff (rst)
        arb_hit |=> !sda_oe_q && !scl_oe_q && lost_q && state_q == ST_LOST)
        else $error("lines kept after lost arbitration");

endmodule

// >>> testbench/i2cm_slave_model.sv
/* two-wire slave device model: stores written bytes, returns read data.
   assumes pull-ups turn the pulls of all parties into line levels. */
`timescale 1ns/1ps

module i2cm_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h3B
) (
    // line levels
    input  wire logic scl,
    input  wire logic sda,
    // pulls, high drives the line low
    output logic      scl_pull,
    output logic      sda_pull,
    // stall after each written data byte, not after the address byte
    input  wire logic stretch
);
    logic [7:0] rx_store[$];
    logic [7:0] mem[4] = '{8'hC3, 8'h5A, 8'h81, 8'h3C};
    logic       last_nak = 1'b0;
    logic       rs = 1'b0;

    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            b[i] = sda;
        end
        @(negedge scl);
    endtask

    task automatic ack_slot();
        sda_pull = 1'b1;
        @(negedge scl);
        sda_pull = 1'b0;
    endtask

    task automatic xfer();
        logic [7:0] b;
        logic       dir;
        int         k;
        get_byte(b);
        dir = b[0];
        if (b[7:1] != OWN_ADDR) wait (0);
        ack_slot();
        k = 0;
        forever begin
            if (dir) begin
                for (int i = 7; i >= 0; i--) begin
                    sda_pull = !mem[k][i];
                    @(negedge scl);
                end
                k++;
                sda_pull = 1'b0;
                @(posedge scl);
                last_nak = sda;
                @(negedge scl);
                if (last_nak) wait (0);
            end else begin
                get_byte(b);
                rx_store.push_back(b);
                ack_slot();
                if (stretch) begin
                    scl_pull = 1'b1;
                    #3000;
                    scl_pull = 1'b0;
                end
            end
        end
    endtask

    // a frame ends on stop or on a repeated start
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        forever begin
            if (!rs) @(negedge sda iff scl === 1'b1);
            rs = 1'b0;
            fork : frame
                xfer();
                @(posedge sda iff scl === 1'b1);
                begin
                    @(negedge sda iff scl === 1'b1);
                    rs = 1'b1;
                end
            join_any
            disable frame;
            sda_pull = 1'b0;
            scl_pull = 1'b0;
        end
    end
endmodule

// >>> testbench/tb_two_wire_master_slave_controller.sv
/* bench for the two-wire bus master against a slave model.
   assumes pull-ups on both lines and a 100 MHz ref_clk. */
`timescale 1ns/1ps

module tb_two_wire_master_slave_controller;
    logic                    ref_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    cmd_valid = 1'b0;
    logic                    cmd_start = 1'b0;
    logic                    cmd_stop = 1'b0;
    logic                    cmd_read = 1'b0;
    logic                    cmd_nack = 1'b0;
    i2cm_pkg::i2cm_byte_type cmd_data = 8'h00;
    i2cm_pkg::i2cm_byte_type rx_data;
    logic                    rx_ready = 1'b1;
    logic                    tb_sda_pull = 1'b0;
    logic                    stretch = 1'b0;
    logic                    cmd_ready, rx_valid, done, ack_error, arb_lost, bus_busy;
    logic                    scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
    wire logic               scl = !(scl_oe | scl_pull);
    wire logic               sda = !(sda_oe | sda_pull | tb_sda_pull);
    logic [7:0]              rx_q[$];
    int                      failures = 0;
    int                      check_count = 0;
    int                      cyc = 0;

    i2cm_master i2cm_master_inst (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
        .cmd_nack(cmd_nack), .cmd_data(cmd_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .done(done), .ack_error(ack_error),
        .arb_lost(arb_lost), .bus_busy(bus_busy), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
    );

    i2cm_slave_model i2cm_slave_model_inst (
        .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull), .stretch(stretch)
    );

    always #5 ref_clk = ~ref_clk;

    // receive sink and hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
        if (cyc > 60000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_t(input string what, input time lo, input time hi, input time seen);
        check_count++;
        if (seen < lo || seen > hi) begin
            failures++;
            $display("ERROR %s expected %0t to %0t seen %0t", what, lo, hi, seen);
        end
    endtask

    task automatic cmd(input logic s, p, r, n, input logic [7:0] d);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_start <= s;
        cmd_stop  <= p;
        cmd_read  <= r;
        cmd_nack  <= n;
        cmd_data  <= d;
        @(posedge ref_clk iff cmd_ready === 1'b1);
        cmd_valid <= 1'b0;
    endtask

    task automatic xb(input logic s, p, r, n, input logic [7:0] d);
        cmd(s, p, r, n, d);
        @(posedge ref_clk iff done === 1'b1);
    endtask

    task automatic t_write();
        time t0;
        stretch <= 1'b1;
        xb(1'b1, 1'b0, 1'b0, 1'b0, 8'h76);
        chk("wr_addr", 8'h02, {6'h0, bus_busy, ack_error});
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5);
        @(posedge scl);
        t0 = $time;
        @(posedge scl);
        // one bit: 2 * (1 + 12) * (6 + 4) * 10 ns
        chk_t("bit_time", 2600, 2650, $time - t0);
        @(posedge ref_clk iff done === 1'b1);
        @(posedge ref_clk iff bus_busy === 1'b0);
        chk("wr_byte", 8'hA5, i2cm_slave_model_inst.rx_store[$]);
        chk("wr_ack", 8'h00, {7'h0, ack_error});
    endtask

    task automatic t_read();
        stretch <= 1'b0;
        rx_ready <= 1'b0;
        xb(1'b1, 1'b0, 1'b0, 1'b0, 8'h76);
        xb(1'b0, 1'b0, 1'b0, 1'b0, 8'h10);
        xb(1'b1, 1'b0, 1'b0, 1'b0, 8'h77);
        chk("rd_addr", 8'h02, {6'h0, bus_busy, ack_error});
        xb(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk("rd_ack", 8'h00, {7'h0, i2cm_slave_model_inst.last_nak});
        xb(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        repeat (3000) @(posedge ref_clk);
        chk("rd_stall", 8'h03, {6'h0, scl_oe, rx_valid});
        rx_ready <= 1'b1;
        @(posedge ref_clk iff bus_busy === 1'b0);
        chk("rd_count", 8'h03, 8'(rx_q.size()));
        foreach (rx_q[i]) chk("rd_byte", i2cm_slave_model_inst.mem[i], rx_q[i]);
        chk("rd_nak", 8'h01, {7'h0, i2cm_slave_model_inst.last_nak});
    endtask

    task automatic t_nack();
        xb(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
        chk("nak_err", 8'h01, {7'h0, ack_error});
        @(posedge ref_clk iff bus_busy === 1'b0);
        chk("nak_idle", 8'h03, {6'h0, scl, sda});
    endtask

    task automatic t_arb();
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hFE);
        @(negedge scl);
        @(posedge ref_clk);
        tb_sda_pull <= 1'b1;
        @(posedge ref_clk iff done === 1'b1);
        chk("arb", 8'h04, {5'h0, arb_lost, scl_oe, sda_oe});
        fork
            cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'h76);
            begin
                repeat (1000) @(posedge ref_clk);
                chk("arb_wait", 8'h01, {5'h0, scl_oe, sda_oe, bus_busy});
                tb_sda_pull <= 1'b0;
            end
        join
        @(posedge ref_clk iff done === 1'b1);
        chk("arb_retry", 8'h00, {6'h0, arb_lost, ack_error});
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        chk("reset_pins", 8'h00, {2'h0, scl_oe, sda_oe, cmd_ready, bus_busy, scl_out, sda_out});
        rst <= 1'b0;
        t_write();
        t_read();
        t_nack();
        t_arb();
        final_report();
    end
endmodule
